// *** hdl/program_page_and_data_bank_mapper.sv ***
`timescale 1ns/1ps
module program_page_and_data_bank_mapper #(
	parameter int PROG_WORDS = 8192,
	parameter int NUM_BANKS  = 4,
	parameter bit COMMON_RAM = 1'b1
) (
	input  wire logic                    I_CLK,
	input  wire logic                    I_RST_N,
	input  wire mapper_pkg::file_req_type I_FILE_REQ,
	input  wire mapper_pkg::pc_req_type   I_PC_REQ,
	output logic [7:0]                   O_FILE_RDATA,
	output logic [12:0]                  O_FETCH_ADDR,
	output logic [7:0]                   O_STATUS,
	output logic [7:0]                   O_PC_HIGH_LATCH,
	output logic [7:0]                   O_INT_CONTROL
);

	localparam int RAM_DEPTH = NUM_BANKS * mapper_pkg::BANK_RAM_BYTES;

	// ==========================================================
	// Core registers
	logic [12:0] pc;
	logic [7:0]  status;
	logic [7:0]  pointer;
	logic [7:0]  latch;
	logic [7:0]  intc;
	logic [7:0]  ram [RAM_DEPTH];

	// ==========================================================
	// Data address forming
	wire         direct_port = I_FILE_REQ.file ==
		mapper_pkg::OFF_INDIRECT_PORT;
	wire [8:0]   direct_addr = {status[mapper_pkg::STATUS_DIR_SEL_HI],
		status[mapper_pkg::STATUS_DIR_SEL_LO], I_FILE_REQ.file}; // RULE_18
	wire [8:0]   indirect_addr = {status[mapper_pkg::STATUS_IND_BANK_BIT],
		pointer}; // RULE_15
	// One address per cycle, no pipeline stage in the decode path
	wire [8:0]   eff_addr = direct_port ? indirect_addr
		: direct_addr; // RULE_19
	wire [1:0]   bank = eff_addr[8:7]; // RULE_07 RULE_08
	wire [6:0]   off  = eff_addr[6:0]; // RULE_09
	// Pointer aimed at the port itself: read zero, write dropped
	wire         self_ref = direct_port &&
		off == mapper_pkg::OFF_INDIRECT_PORT; // RULE_16

	// Mirrored core registers ignore the bank entirely
	wire hit_pcl   = off == mapper_pkg::OFF_PC_LOW; // RULE_13
	wire hit_stat  = off == mapper_pkg::OFF_STATUS; // RULE_13
	wire hit_ptr   = off == mapper_pkg::OFF_POINTER; // RULE_13
	wire hit_latch = off == mapper_pkg::OFF_PC_HIGH_LATCH; // RULE_13
	wire hit_intc  = off == mapper_pkg::OFF_INT_CONTROL; // RULE_13

	// Common window folds onto bank 0 storage
	wire         in_common = COMMON_RAM &&
		off >= mapper_pkg::OFF_COMMON_FIRST; // RULE_10
	wire [1:0]   ram_bank  = in_common ? 2'h0 : bank; // RULE_10
	wire         bank_ok   = 32'(ram_bank) < NUM_BANKS; // RULE_11
	wire         hit_ram   = off >= mapper_pkg::OFF_RAM_FIRST && bank_ok;
	wire [8:0]   ram_idx   = 9'(32'(ram_bank) *
		mapper_pkg::BANK_RAM_BYTES) +
		9'(off - mapper_pkg::OFF_RAM_FIRST);

	wire         wr_en = I_FILE_REQ.wr && !self_ref; // RULE_16

	// ==========================================================
	// Read selection, zero for anything not implemented
	wire [7:0] ram_q = ram[ram_idx];
	assign O_FILE_RDATA =
		self_ref  ? mapper_pkg::READ_ZERO : // RULE_16
		hit_pcl   ? pc[7:0] :
		hit_stat  ? status :
		hit_ptr   ? pointer :
		hit_latch ? latch :
		hit_intc  ? intc :
		hit_ram   ? ram_q :
		mapper_pkg::READ_ZERO; // RULE_11

	// ==========================================================
	// Program page forming
	// Small parts drop page bits on call and jump only, not on low-byte writes
	wire [1:0] page =
		PROG_WORDS <= mapper_pkg::PAGE_WORDS ? 2'h0 : // RULE_04
		PROG_WORDS <= mapper_pkg::TWO_PAGES ?
			{1'b0, latch[mapper_pkg::LATCH_PAGE_LO]} : // RULE_05
		latch[mapper_pkg::LATCH_PAGE_HI:mapper_pkg::LATCH_PAGE_LO];
	wire [12:0] jump_pc = {page, I_PC_REQ.target}; // RULE_01 RULE_02
	wire        pcl_wr  = wr_en && hit_pcl;

	// Return beats jump beats low-byte write beats advance
	wire [12:0] next_pc =
		I_PC_REQ.ret  ? I_PC_REQ.stack_pc : // RULE_03
		I_PC_REQ.jump ? jump_pc :
		pcl_wr ? {latch[4:0], I_FILE_REQ.wdata} : // RULE_17
		I_PC_REQ.advance ? pc + 13'h0001 : pc;

	// Program counter
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pc <= mapper_pkg::PC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	// Single write port: a copy needs a read then a write cycle
	always_ff @(posedge I_CLK or negedge I_RST_N) begin // RULE_14
		if (!I_RST_N) begin
			status  <= mapper_pkg::STATUS_RESET;
			pointer <= mapper_pkg::POINTER_RESET;
			latch   <= mapper_pkg::LATCH_RESET;
			intc    <= mapper_pkg::INTC_RESET;
		end else if (wr_en) begin
			if (hit_stat) begin
				status <= I_FILE_REQ.wdata; // RULE_06
			end
			if (hit_ptr) begin
				pointer <= I_FILE_REQ.wdata;
			end
			if (hit_latch) begin
				latch <= I_FILE_REQ.wdata;
			end
			if (hit_intc) begin
				intc <= I_FILE_REQ.wdata;
			end
		end
	end

	// General RAM has no reset so its contents survive every reset
	always_ff @(posedge I_CLK) begin // RULE_12
		if (wr_en && hit_ram) begin
			ram[ram_idx] <= I_FILE_REQ.wdata;
		end
	end

	assign O_FETCH_ADDR    = pc;
	assign O_STATUS        = status;
	assign O_PC_HIGH_LATCH = latch;
	assign O_INT_CONTROL   = intc;

	// ==========================================================
	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	a_jump_page_bits: assert property ( // RULE_02
		I_PC_REQ.jump && !I_PC_REQ.ret && PROG_WORDS > 4096 |=>
		O_FETCH_ADDR == {$past(latch[4:3]), $past(I_PC_REQ.target)})
		else $error("jump page bits wrong");

	a_jump_low_field: assert property ( // RULE_01
		I_PC_REQ.jump && !I_PC_REQ.ret |=>
		O_FETCH_ADDR[10:0] == $past(I_PC_REQ.target))
		else $error("jump target field wrong");

	a_return_restore: assert property ( // RULE_03
		I_PC_REQ.ret |=> O_FETCH_ADDR == $past(I_PC_REQ.stack_pc))
		else $error("return did not restore counter");

	a_small_no_page: assert property ( // RULE_04
		I_PC_REQ.jump && !I_PC_REQ.ret && PROG_WORDS <= 2048 |=>
		O_FETCH_ADDR[12:11] == 2'h0)
		else $error("small part used page bits");

	a_mid_no_top: assert property ( // RULE_05
		I_PC_REQ.jump && !I_PC_REQ.ret && PROG_WORDS > 2048 &&
		PROG_WORDS <= 4096 |=> O_FETCH_ADDR[12] == 1'b0)
		else $error("mid part used upper page bit");

	a_pcl_write_load: assert property ( // RULE_17
		pcl_wr && !I_PC_REQ.ret && !I_PC_REQ.jump |=>
		O_FETCH_ADDR == {$past(latch[4:0]), $past(I_FILE_REQ.wdata)})
		else $error("low byte write did not load top bits");

	a_self_read_zero: assert property ( // RULE_16
		self_ref |-> O_FILE_RDATA == 8'h00)
		else $error("self indirect read not zero");

	a_self_write_drop: assert property ( // RULE_16
		self_ref && I_FILE_REQ.wr |=> $stable(status) &&
		$stable(pointer) && $stable(latch) && $stable(intc))
		else $error("self indirect write took effect");

	a_mirror_status: assert property ( // RULE_13
		I_FILE_REQ.rd && !direct_port &&
		I_FILE_REQ.file == 7'h03 |-> O_FILE_RDATA == status)
		else $error("status not mirrored");

	a_unimpl_zero: assert property ( // RULE_11
		!direct_port && I_FILE_REQ.file == 7'h01 |->
		O_FILE_RDATA == 8'h00)
		else $error("unimplemented location not zero");

	a_direct_bank: assert property ( // RULE_07
		!direct_port |-> bank == status[6:5])
		else $error("direct bank select wrong");

	a_indirect_bank: assert property ( // RULE_08
		direct_port |-> bank[1] == status[7] && bank[0] == pointer[7])
		else $error("indirect bank select wrong");

	a_common_fold: assert property ( // RULE_10
		COMMON_RAM && off >= 7'h70 |-> ram_idx ==
		9'(off - 7'h20))
		else $error("common window not folded");

	a_ram_roundtrip: assert property ( // RULE_09
		wr_en && hit_ram && !I_FILE_REQ.rd ##1
		!I_FILE_REQ.wr && $past(eff_addr) == eff_addr |->
		O_FILE_RDATA == $past(I_FILE_REQ.wdata))
		else $error("RAM readback mismatch");


	// ==========================================================
	// Register map checks, any bank; mirror and hole checks use direct access only
	a_mirror_pcl: assert property ( // RULE_13
		I_FILE_REQ.rd && !direct_port &&
		I_FILE_REQ.file == 7'h02 |-> O_FILE_RDATA == pc[7:0])
		else $error("low byte not mirrored");

	a_mirror_pointer: assert property ( // RULE_13
		I_FILE_REQ.rd && !direct_port &&
		I_FILE_REQ.file == 7'h04 |-> O_FILE_RDATA == pointer)
		else $error("pointer not mirrored");

	a_mirror_latch: assert property ( // RULE_13
		I_FILE_REQ.rd && !direct_port &&
		I_FILE_REQ.file == 7'h0A |-> O_FILE_RDATA == latch)
		else $error("high latch not mirrored");

	a_mirror_intc: assert property ( // RULE_13
		I_FILE_REQ.rd && !direct_port &&
		I_FILE_REQ.file == 7'h0B |-> O_FILE_RDATA == intc)
		else $error("interrupt control not mirrored");

	a_indirect_addr: assert property ( // RULE_15
		direct_port |-> eff_addr == {status[7], pointer})
		else $error("indirect address wrong");

	a_direct_addr: assert property ( // RULE_18
		!direct_port |-> eff_addr == {status[6:5], I_FILE_REQ.file})
		else $error("direct address wrong");

	a_status_write: assert property ( // RULE_06
		wr_en && hit_stat |=>
		O_STATUS == $past(I_FILE_REQ.wdata))
		else $error("status write lost");

	a_pointer_write: assert property ( // RULE_13
		wr_en && hit_ptr |=>
		pointer == $past(I_FILE_REQ.wdata))
		else $error("pointer write lost");

	a_latch_write: assert property ( // RULE_13
		wr_en && hit_latch |=>
		O_PC_HIGH_LATCH == $past(I_FILE_REQ.wdata))
		else $error("latch write lost");

	a_intc_write: assert property ( // RULE_13
		wr_en && hit_intc |=>
		O_INT_CONTROL == $past(I_FILE_REQ.wdata))
		else $error("interrupt control write lost");

	a_sfr_hole_zero: assert property ( // RULE_11
		!direct_port && I_FILE_REQ.file >= 7'h0C &&
		I_FILE_REQ.file < 7'h20 |-> O_FILE_RDATA == 8'h00)
		else $error("unused special offset not zero");

	a_bad_bank_zero: assert property ( // RULE_11
		off >= 7'h20 && !in_common && 32'(bank) >= NUM_BANKS |->
		O_FILE_RDATA == 8'h00)
		else $error("missing bank not zero");

	a_hole_write_drop: assert property ( // RULE_11
		I_FILE_REQ.wr && !direct_port && I_FILE_REQ.file == 7'h05 |=>
		$stable(status) && $stable(pointer) &&
		$stable(latch) && $stable(intc))
		else $error("hole write took effect");

	a_ram_same_cycle: assert property ( // RULE_19
		hit_ram && !self_ref |-> O_FILE_RDATA == ram_q)
		else $error("RAM read not in same cycle");

	a_common_shared: assert property ( // RULE_10
		wr_en && hit_ram && in_common ##1 !I_FILE_REQ.wr &&
		hit_ram && in_common && $past(off) == off |->
		O_FILE_RDATA == $past(I_FILE_REQ.wdata))
		else $error("common byte differs between banks");

	a_mid_full: assert property ( // RULE_05
		I_PC_REQ.jump && !I_PC_REQ.ret && PROG_WORDS > 2048 &&
		PROG_WORDS <= 4096 |=> O_FETCH_ADDR ==
		{1'b0, $past(latch[3]), $past(I_PC_REQ.target)})
		else $error("mid part jump address wrong");

	a_small_full: assert property ( // RULE_04
		I_PC_REQ.jump && !I_PC_REQ.ret && PROG_WORDS <= 2048 |=>
		O_FETCH_ADDR == {2'h0, $past(I_PC_REQ.target)})
		else $error("small part jump address wrong");

	c_jump_taken: cover property (I_PC_REQ.jump ##1 I_PC_REQ.ret);
	c_indirect_ram: cover property (direct_port && hit_ram && wr_en);
	c_common_access: cover property (in_common && bank == 2'h3 && wr_en);
	c_pcl_write: cover property (pcl_wr);
	c_ret_over_jump: cover property (I_PC_REQ.ret && I_PC_REQ.jump);

endmodule

// *** hdl/mapper_pkg.sv ***
// Contract
// (RULE_01) Call and jump carry only an 11-bit target within one 2K page.
// (RULE_02) Call or jump takes latch bits 4:3 as the two upper page bits.
// (RULE_03) Any return reloads the full 13-bit counter from the stack.
// (RULE_04) Parts with at most 2K words ignore both latch page bits.
// (RULE_05) Parts up to 4K words ignore the upper latch page bit.
// (RULE_06) Bank selection bits live in status bits 7:5.
// (RULE_07) Direct access picks bank from the two direct bank-select bits.
// (RULE_08) Indirect access uses the indirect bank bit: banks 0/1 or 2/3.
// (RULE_09) Each bank spans 128 bytes, special registers low, RAM above.
// (RULE_10) Last 16 bytes of banks 1 to 3 map onto bank 0 70h-7Fh.
// (RULE_11) Unimplemented locations and unimplemented banks read as zero.
// (RULE_12) General RAM is never initialised nor changed by any reset.
// (RULE_13) Core registers appear at the same offset in all four banks.
// (RULE_14) Register copies pass through the working register: two cycles.
// (RULE_15) Indirect address is the indirect bank bit above the 8-bit pointer.
// (RULE_16) Indirect port addressing itself reads 00h and ignores writes.
// (RULE_17) Writing the counter low byte loads latch bits 4:0 into the top.
// (RULE_18) Direct address is the two bank bits above the 7-bit file field.
// (RULE_19) Bank decode completes in the same cycle as the access.
package mapper_pkg;

	// ==========================================================
	// Register offsets within a bank
	localparam logic [6:0] OFF_INDIRECT_PORT = 7'h00;
	localparam logic [6:0] OFF_PC_LOW        = 7'h02;
	localparam logic [6:0] OFF_STATUS        = 7'h03;
	localparam logic [6:0] OFF_POINTER       = 7'h04;
	localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0A;
	localparam logic [6:0] OFF_INT_CONTROL   = 7'h0B;
	localparam logic [6:0] OFF_RAM_FIRST     = 7'h20;
	localparam logic [6:0] OFF_COMMON_FIRST  = 7'h70;
	localparam int         BANK_RAM_BYTES    = 96;

	// ==========================================================
	// Field positions
	localparam int STATUS_IND_BANK_BIT = 7;
	localparam int STATUS_DIR_SEL_HI   = 6;
	localparam int STATUS_DIR_SEL_LO   = 5;
	localparam int LATCH_PAGE_HI       = 4;
	localparam int LATCH_PAGE_LO       = 3;
	localparam int TARGET_BITS         = 11;
	localparam int PC_BITS             = 13;

	// ==========================================================
	// Reset values and sizes
	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam logic [7:0]  LATCH_RESET   = 8'h00;
	localparam logic [7:0]  POINTER_RESET = 8'h00;
	localparam logic [7:0]  INTC_RESET    = 8'h00;
	localparam logic [12:0] PC_RESET      = 13'h0000;
	localparam logic [7:0]  READ_ZERO     = 8'h00;
	localparam int          PAGE_WORDS    = 2048;
	localparam int          TWO_PAGES     = 4096;

	// Register-file request from execute
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] file;
		logic [7:0] wdata;
	} file_req_type;

	// Program-counter request from decode
	typedef struct packed {
		logic        jump;
		logic        ret;
		logic        advance;
		logic [10:0] target;
		logic [12:0] stack_pc;
	} pc_req_type;

endpackage

// *** dv/core_model.sv ***
`timescale 1ns/1ps
// ====
// Core side: one request per cycle
module core_model (
	input  wire logic                i_clk,
	input  wire logic [7:0]          i_rdata,
	output mapper_pkg::file_req_type o_file,
	output mapper_pkg::pc_req_type   o_pc
);
	// Idle at time zero so nothing is taken in reset
	initial begin
		o_file = '0;
		o_pc = '0;
	end

	// Change just after an edge, hold one full cycle
	task automatic put(input logic [17:0] f, input logic [26:0] p);
		@(posedge i_clk);
		o_file <= f;
		o_pc <= p;
		@(negedge i_clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		put({2'b01, a, d}, '0);
	endtask

	// Write data FFh on reads: never a helpful value
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		put({2'b10, a, 8'hFF}, '0);
		d = i_rdata;
	endtask

	// Copy passes through a working byte, so two cycles
	task automatic copy(input logic [6:0] s, input logic [6:0] t);
		logic [7:0] w;
		rd(s, w);
		wr(t, w);
	endtask

	// Kind is {jump, ret, advance}; target only 11 bits
	task automatic pcq(input logic [2:0] k, input logic [10:0] t,
		input logic [12:0] s);
		put('0, {k, t, s});
	endtask
endmodule

// *** dv/program_page_and_data_bank_mapper_bench.sv ***
`timescale 1ns/1ps
module program_page_and_data_bank_mapper_bench;
	logic                     clk;
	logic                     rst_n;
	mapper_pkg::file_req_type fq;
	mapper_pkg::pc_req_type   pq;
	logic [7:0]               rdat [3];
	logic [7:0]               st [3];
	logic [7:0]               lat [3];
	logic [7:0]               ic [3];
	logic [12:0]              fa [3];
	int                       fails;
	int                       checks_done;

	// ====
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ====
	// 2K, 4K and 8K parts fed the same requests
	for (genvar g = 0; g < 3; g++) begin : sizes
		program_page_and_data_bank_mapper #(.PROG_WORDS(2048 << g)) dut (
			.I_CLK(clk), .I_RST_N(rst_n), .I_FILE_REQ(fq), .I_PC_REQ(pq),
			.O_FILE_RDATA(rdat[g]), .O_FETCH_ADDR(fa[g]), .O_STATUS(st[g]),
			.O_PC_HIGH_LATCH(lat[g]), .O_INT_CONTROL(ic[g]));
	end

	core_model core (.i_clk(clk), .i_rdata(rdat[2]), .o_file(fq),
		.o_pc(pq));

	// ====
	// Compare and report
	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		core.rd(a, d);
		check({5'h00, d}, {5'h00, e});
	endtask

	task automatic give_verdict;
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hang guard: whole sequence needs well under 200 cycles
	initial begin
		#(25 * 2000);
		fails++;
		give_verdict();
	end

	// ====
	// Main sequence
	initial begin
		rst_n = 1'b0;
		fails = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check({5'h00, st[2]}, 13'h0000);
		check({5'h00, lat[2]}, 13'h0000);
		check({5'h00, ic[2]}, 13'h0000);
		check(fa[2], 13'h0000);
		// A distinct RAM byte per bank, then read each back
		for (int b = 0; b < 4; b++) begin
			core.wr(7'h03, 8'(b) << 5);
			core.wr(7'h20, 8'h10 + 8'(b));
		end
		for (int b = 0; b < 4; b++) begin
			core.wr(7'h03, 8'(b) << 5);
			rchk(7'h03, 8'(b) << 5);
			rchk(7'h20, 8'h10 + 8'(b));
		end
		// Still bank 3: common window, latch, hole
		core.wr(7'h70, 8'hA5);
		core.wr(7'h0A, 8'h18);
		core.wr(7'h05, 8'h77);
		rchk(7'h05, 8'h00);
		core.copy(7'h20, 7'h21);
		rchk(7'h21, 8'h13);
		core.wr(7'h03, 8'h00);
		rchk(7'h70, 8'hA5);
		rchk(7'h0A, 8'h18);
		check({5'h00, lat[2]}, 13'h0018);
		core.wr(7'h0B, 8'h3C);
		core.wr(7'h03, 8'h40);
		rchk(7'h0B, 8'h3C);
		check({5'h00, ic[2]}, 13'h003C);
		// Indirect through upper bank pair
		core.wr(7'h03, 8'h80);
		core.wr(7'h04, 8'hA0);
		rchk(7'h00, 8'h13);
		core.wr(7'h04, 8'h20);
		rchk(7'h00, 8'h12);
		core.wr(7'h04, 8'hF0);
		rchk(7'h00, 8'hA5);
		core.wr(7'h04, 8'h00);
		rchk(7'h04, 8'h00);
		core.wr(7'h00, 8'h55);
		rchk(7'h00, 8'h00);
		// Page bits 4:3 of latch 18h over target 7FFh
		core.pcq(3'b100, 11'h7FF, 13'h0000);
		core.pcq(3'b000, 11'h000, 13'h0000);
		check(fa[0], 13'h07FF);
		check(fa[1], 13'h0FFF);
		check(fa[2], 13'h1FFF);
		// Return beats jump, then advance, then low-byte write
		core.pcq(3'b110, 11'h000, 13'h1234);
		core.pcq(3'b001, 11'h000, 13'h0000);
		check(fa[2], 13'h1234);
		core.wr(7'h02, 8'h5A);
		check(fa[2], 13'h1235);
		core.pcq(3'b000, 11'h000, 13'h0000);
		check(fa[2], 13'h185A);
		rchk(7'h02, 8'h5A);
		// Second reset must leave RAM alone
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk(7'h20, 8'h10);
		check({5'h00, st[2]}, 13'h0000);
		check({5'h00, lat[2]}, 13'h0000);
		check({5'h00, ic[2]}, 13'h0000);
		check(fa[2], 13'h0000);
		give_verdict();
	end
endmodule
